// >>> hw/pmc_pkg.sv
// package: register map, fields and states of the power mode controller
package pmc_pkg;
  // ********************************
  // register offsets
  // ********************************
  localparam logic [11:0] PMC_PLL_CONTROL_REGISTER_OFF   = 12'h000;
  localparam logic [11:0] PMC_VREG_CTL_OFF  = 12'h004;
  localparam logic [11:0] PMC_MODE_CMD_OFF  = 12'h008;
  localparam logic [11:0] PMC_STATUS_OFF    = 12'h00C;
  localparam logic [11:0] PMC_IRQ_STAT_OFF  = 12'h010;
  localparam logic [11:0] PMC_IRQ_MASK_OFF  = 12'h014;
  localparam logic [11:0] PMC_WAKE_CFG_OFF  = 12'h018;
  // ********************************
  // field positions
  // ********************************
  localparam int PMC_PLL_BYPASS_BIT  = 0;
  localparam int PMC_PLL_DIS_BIT     = 1;
  localparam int PMC_PLL_MULT_LSB    = 8;
  localparam int PMC_PLL_MULT_W      = 6;
  localparam int PMC_VREG_REGULATOR_FREQUENCY_FIELD_LSB   = 0;
  localparam int PMC_VREG_REGULATOR_FREQUENCY_FIELD_W     = 2;
  localparam int PMC_CMD_W           = 2;
  localparam int PMC_EVT_W           = 6;
  // ********************************
  // reset values, hibernate code and mode commands
  // ********************************
  localparam logic [5:0] PMC_MULT_RST      = 6'h0A;
  localparam logic [1:0] PMC_VREG_REGULATOR_FREQUENCY_FIELD_RST = 2'h3;
  localparam logic [1:0] PMC_REGULATOR_FREQUENCY_FIELD_HIB      = 2'h0;
  localparam logic [1:0] PMC_CMD_ACTIVE    = 2'h1;
  localparam logic [1:0] PMC_CMD_SLEEP     = 2'h2;
  localparam logic [1:0] PMC_CMD_DEEP      = 2'h3;
  localparam logic [1:0] PMC_CMD_FULL      = 2'h0;
  // event bits of irq status
  localparam int PMC_EV_WAKE      = 0;
  localparam int PMC_EV_ENTER_HIB = 1;
  localparam int PMC_EV_RTC       = 2;
  localparam int PMC_EV_CAN       = 3;
  localparam int PMC_EV_NET       = 4;
  localparam int PMC_EV_MT_IRQ    = 5;

  typedef enum logic [2:0] {
    PMC_FULL_ON,
    PMC_ACTIVE,
    PMC_SLEEP,
    PMC_DEEP_SLEEP,
    PMC_HIBERNATE
  } pmc_state_t;
endpackage : pmc_pkg

// >>> hw/pmc_power_mode_controller.sv
// top: power mode controller with apb registers and wake handling
// How it works
// - reset and power-up land in full-on, pll on, not bypassed, clocks run
// - active bypasses the pll, which stays on unless its disable bit is written in active, clocks at input rate
// - multiplier written in active is pending until next full-on entry
// - active keeps granting dma to permitted level-one memories
// - sleep stops core clock, pll and system clock keep running
// - sleep wake samples bypass bit: clear to full-on, set to active
// - sleep refuses system dma to level-one memory
// - deep sleep disables pll and stops both clocks
// - deep sleep leaves only on reset or rtc interrupt, rtc goes active
// - reset during deep sleep moves to full-on
// - writing zero to regulator frequency enters hibernate, core supply off
// - hibernate puts external pins in high impedance
// - hibernate exits on rtc, can traffic, reset or network receive-on
// - unused can or transceiver wake input serves as general wakeup
// - transceiver wake on preamble or its interrupt ends sleep
// - network activity wakes from sleep or hibernate, regulator back up
`timescale 1ns/1ps
module pmc_power_mode_controller
  import pmc_pkg::*;
(
  input  wire logic        CLK_SYS_IN,
  input  wire logic        RST_IN,
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [11:0] PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  output logic      [31:0] PRDATA_OUT,
  output logic             PREADY_OUT,
  output logic             PSLVERR_OUT,
  input  wire logic        RTC_WAKE_IN,
  input  wire logic        CAN_WAKE_IN,
  input  wire logic        NET_RX_ON_IN,
  input  wire logic        MT_PREAMBLE_IN,
  input  wire logic        MT_IRQ_IN,
  input  wire logic        DMA_REQ_IN,
  output logic             DMA_GRANT_OUT,
  output logic             PLL_EN_OUT,
  output logic             PLL_BYPASS_OUT,
  output logic      [5:0]  PLL_MULT_OUT,
  output logic             CORE_CLK_EN_OUT,
  output logic             SYS_CLK_EN_OUT,
  output logic             CORE_SUPPLY_ON_OUT,
  output logic             PINS_HIZ_OUT,
  output logic      [2:0]  STATE_OUT,
  output logic             IRQ_OUT
);
  // ********************************
  // registers
  // ********************************
  pmc_state_t  state_r, state_nxt;
  logic        bypass_r;
  logic        pll_dis_r;
  logic [5:0]  mult_req_r;
  logic [5:0]  mult_act_r;
  logic [1:0]  regulator_frequency_field_r;
  logic [1:0]  wake_cfg_r;
  logic [5:0]  irq_stat_r;
  logic [5:0]  irq_mask_r;
  logic [31:0] prdata_r;
  logic        dma_grant_r;

  // ********************************
  // bus decode
  // ********************************
  wire wr_en      = PSEL_IN & PENABLE_IN & PWRITE_IN;
  wire hit_pll    = PADDR_IN == PMC_PLL_CONTROL_REGISTER_OFF;
  wire hit_vreg   = PADDR_IN == PMC_VREG_CTL_OFF;
  wire hit_cmd    = PADDR_IN == PMC_MODE_CMD_OFF;
  wire hit_stat   = PADDR_IN == PMC_STATUS_OFF;
  wire hit_istat  = PADDR_IN == PMC_IRQ_STAT_OFF;
  wire hit_imask  = PADDR_IN == PMC_IRQ_MASK_OFF;
  wire hit_wcfg   = PADDR_IN == PMC_WAKE_CFG_OFF;
  wire hit_any    = hit_pll | hit_vreg | hit_cmd | hit_stat | hit_istat | hit_imask | hit_wcfg;
  wire bus_live   = state_r != PMC_HIBERNATE;
  wire run_st     = state_r == PMC_FULL_ON || state_r == PMC_ACTIVE;
  wire wr_pll     = wr_en & hit_pll & bus_live;
  wire wr_vreg    = wr_en & hit_vreg & run_st;
  wire wr_cmd     = wr_en & hit_cmd & run_st;
  wire [1:0] cmd  = PWDATA_IN[PMC_CMD_W-1:0];
  wire [1:0] new_regulator_frequency_field = PWDATA_IN[PMC_VREG_REGULATOR_FREQUENCY_FIELD_LSB +: PMC_VREG_REGULATOR_FREQUENCY_FIELD_W];
  wire [5:0] new_mult = PWDATA_IN[PMC_PLL_MULT_LSB +: PMC_PLL_MULT_W];

  // ********************************
  // wake sources
  // ********************************
  // unused can or transceiver input doubles as a general wake pin
  wire can_wake   = CAN_WAKE_IN;
  wire net_wake   = NET_RX_ON_IN | (wake_cfg_r[1] & MT_IRQ_IN);
  wire mt_wake    = MT_PREAMBLE_IN | MT_IRQ_IN;
  wire sleep_wake = RTC_WAKE_IN | can_wake | mt_wake | net_wake;
  wire hib_wake   = RTC_WAKE_IN | can_wake | net_wake;
  wire pll_on     = ~pll_dis_r;

  // ********************************
  // mode sequencing
  // ********************************
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      PMC_FULL_ON, PMC_ACTIVE: begin
        if (wr_vreg && new_regulator_frequency_field == PMC_REGULATOR_FREQUENCY_FIELD_HIB) begin
          state_nxt = PMC_HIBERNATE;
        end else if (wr_cmd) begin
          case (cmd)
            PMC_CMD_FULL:   state_nxt = pll_on ? PMC_FULL_ON : state_r;
            PMC_CMD_ACTIVE: state_nxt = PMC_ACTIVE;
            PMC_CMD_SLEEP:  state_nxt = pll_on ? PMC_SLEEP : state_r;
            default:        state_nxt = PMC_DEEP_SLEEP;
          endcase
        end
      end
      PMC_SLEEP: begin
        if (sleep_wake) begin
          state_nxt = bypass_r ? PMC_ACTIVE : PMC_FULL_ON;
        end
      end
      PMC_DEEP_SLEEP: begin
        if (RTC_WAKE_IN) begin
          state_nxt = PMC_ACTIVE;
        end
      end
      PMC_HIBERNATE: begin
        if (hib_wake) begin
          state_nxt = PMC_FULL_ON;
        end
      end
      default: state_nxt = PMC_FULL_ON;
    endcase
  end

  wire wake_evt  = (state_r != PMC_FULL_ON) && (state_r != PMC_ACTIVE) &&
                   (state_nxt == PMC_FULL_ON || state_nxt == PMC_ACTIVE);
  wire hib_evt   = state_r != PMC_HIBERNATE && state_nxt == PMC_HIBERNATE;
  wire [5:0] evt = {MT_IRQ_IN, NET_RX_ON_IN, CAN_WAKE_IN, RTC_WAKE_IN, hib_evt, wake_evt};
  wire enter_full = state_nxt == PMC_FULL_ON && state_r != PMC_FULL_ON;
  // grant follows the state being entered, so sleep never shows a stale one
  wire nxt_run    = state_nxt == PMC_FULL_ON || state_nxt == PMC_ACTIVE;

  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      state_r <= PMC_FULL_ON;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ********************************
  // control registers
  // ********************************
  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      bypass_r   <= 1'b0;
      pll_dis_r  <= 1'b0;
      mult_req_r <= PMC_MULT_RST;
      mult_act_r <= PMC_MULT_RST;
      regulator_frequency_field_r     <= PMC_VREG_REGULATOR_FREQUENCY_FIELD_RST;
      wake_cfg_r <= 2'h0;
      irq_mask_r <= 6'h00;
    end else begin
      if (wr_pll) begin
        bypass_r   <= PWDATA_IN[PMC_PLL_BYPASS_BIT];
        pll_dis_r  <= PWDATA_IN[PMC_PLL_DIS_BIT] & (state_r == PMC_ACTIVE);
        mult_req_r <= new_mult;
        if (state_r == PMC_FULL_ON || enter_full) begin
          mult_act_r <= new_mult;
        end
      end else if (enter_full) begin
        mult_act_r <= mult_req_r;
      end
      if (wr_vreg) begin
        regulator_frequency_field_r <= new_regulator_frequency_field;
      end else if (state_r == PMC_HIBERNATE && hib_wake) begin
        regulator_frequency_field_r    <= PMC_VREG_REGULATOR_FREQUENCY_FIELD_RST;
        pll_dis_r <= 1'b0;
      end
      if (wr_en && hit_wcfg) begin
        wake_cfg_r <= PWDATA_IN[1:0];
      end
      if (wr_en && hit_imask) begin
        irq_mask_r <= PWDATA_IN[PMC_EVT_W-1:0];
      end
    end
  end

  // sticky events, set wins over write-one-to-clear
  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      irq_stat_r <= 6'h00;
    end else begin
      irq_stat_r <= (irq_stat_r & ~((wr_en && hit_istat) ? PWDATA_IN[5:0] : 6'h00)) | evt;
    end
  end

  // ********************************
  // read path
  // ********************************
  wire [31:0] rd_mux =
    hit_pll   ? {18'h0, mult_req_r, 6'h0, pll_dis_r, bypass_r} :
    hit_vreg  ? {30'h0, regulator_frequency_field_r} :
    hit_stat  ? {23'h0, mult_act_r, state_r} :
    hit_istat ? {26'h0, irq_stat_r} :
    hit_imask ? {26'h0, irq_mask_r} :
    hit_wcfg  ? {30'h0, wake_cfg_r} : 32'h0000_0000;

  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      prdata_r    <= 32'h0000_0000;
      dma_grant_r <= 1'b0;
    end else begin
      if (PSEL_IN && !PENABLE_IN && !PWRITE_IN) begin
        prdata_r <= rd_mux;
      end
      dma_grant_r <= DMA_REQ_IN && nxt_run;
    end
  end

  // ********************************
  // outputs
  // ********************************
  assign PRDATA_OUT         = prdata_r;
  assign PREADY_OUT         = 1'b1;
  assign PSLVERR_OUT        = PSEL_IN & PENABLE_IN & ~hit_any;
  assign DMA_GRANT_OUT      = dma_grant_r;
  assign PLL_EN_OUT         = (state_r == PMC_FULL_ON || state_r == PMC_SLEEP ||
                               (state_r == PMC_ACTIVE && pll_on));
  assign PLL_BYPASS_OUT     = state_r == PMC_ACTIVE;
  assign PLL_MULT_OUT       = mult_act_r;
  assign CORE_CLK_EN_OUT    = state_r == PMC_FULL_ON || state_r == PMC_ACTIVE;
  assign SYS_CLK_EN_OUT     = CORE_CLK_EN_OUT || state_r == PMC_SLEEP;
  assign CORE_SUPPLY_ON_OUT = state_r != PMC_HIBERNATE;
  assign PINS_HIZ_OUT       = state_r == PMC_HIBERNATE;
  assign STATE_OUT          = state_r;
  assign IRQ_OUT            = |(irq_stat_r & irq_mask_r);

  // ********************************
  // assertions
  // ********************************
  property p_reset_full;
    @(posedge CLK_SYS_IN) RST_IN |=> (state_r == PMC_FULL_ON && PLL_EN_OUT && !PLL_BYPASS_OUT);
  endproperty
  a_reset_full: assert property (p_reset_full) else $error("reset not full-on");

  property p_active_bypass;
    @(posedge CLK_SYS_IN) disable iff (RST_IN)
      state_r == PMC_ACTIVE |-> PLL_BYPASS_OUT && CORE_CLK_EN_OUT && SYS_CLK_EN_OUT;
  endproperty
  a_active_bypass: assert property (p_active_bypass) else $error("active clocks wrong");

  property p_mult_hold;
    @(posedge CLK_SYS_IN) disable iff (RST_IN)
      state_r == PMC_ACTIVE && state_nxt == PMC_ACTIVE |=> $stable(mult_act_r);
  endproperty
  a_mult_hold: assert property (p_mult_hold) else $error("multiplier changed in active");

  property p_sleep_clk;
    @(posedge CLK_SYS_IN) disable iff (RST_IN)
      state_r == PMC_SLEEP |-> !CORE_CLK_EN_OUT && SYS_CLK_EN_OUT && PLL_EN_OUT;
  endproperty
  a_sleep_clk: assert property (p_sleep_clk) else $error("sleep clocks wrong");

  property p_sleep_wake;
    @(posedge CLK_SYS_IN) disable iff (RST_IN)
      state_r == PMC_SLEEP && sleep_wake |=> state_r == (bypass_r ? PMC_ACTIVE : PMC_FULL_ON);
  endproperty
  a_sleep_wake: assert property (p_sleep_wake) else $error("sleep wake target wrong");

  property p_deep_off;
    @(posedge CLK_SYS_IN) disable iff (RST_IN)
      state_r == PMC_DEEP_SLEEP |-> !PLL_EN_OUT && !CORE_CLK_EN_OUT && !SYS_CLK_EN_OUT;
  endproperty
  a_deep_off: assert property (p_deep_off) else $error("deep sleep clocks on");

  sequence s_deep_left;
    state_r == PMC_DEEP_SLEEP ##1 state_r != PMC_DEEP_SLEEP;
  endsequence

  property p_deep_exit;
    @(posedge CLK_SYS_IN) disable iff (RST_IN)
      s_deep_left |-> state_r == PMC_ACTIVE && $past(RTC_WAKE_IN);
  endproperty
  a_deep_exit: assert property (p_deep_exit) else $error("bad deep sleep exit");

  property p_hib_enter;
    @(posedge CLK_SYS_IN) disable iff (RST_IN)
      wr_vreg && new_regulator_frequency_field == PMC_REGULATOR_FREQUENCY_FIELD_HIB |=> !CORE_SUPPLY_ON_OUT && PINS_HIZ_OUT;
  endproperty
  a_hib_enter: assert property (p_hib_enter) else $error("hibernate not entered");

  property p_hib_wake;
    @(posedge CLK_SYS_IN) disable iff (RST_IN)
      state_r == PMC_HIBERNATE && hib_wake |=> state_r == PMC_FULL_ON && CORE_SUPPLY_ON_OUT;
  endproperty
  a_hib_wake: assert property (p_hib_wake) else $error("hibernate wake missed");

  property p_full_on;
    @(posedge CLK_SYS_IN) disable iff (RST_IN)
      state_r == PMC_FULL_ON |-> PLL_EN_OUT && !PLL_BYPASS_OUT &&
      CORE_CLK_EN_OUT && SYS_CLK_EN_OUT;
  endproperty
  a_full_on: assert property (p_full_on) else $error("full-on outputs wrong");

  property p_pll_gate;
    @(posedge CLK_SYS_IN) disable iff (RST_IN)
      wr_cmd && pll_dis_r && (cmd == PMC_CMD_FULL || cmd == PMC_CMD_SLEEP) |=> $stable(state_r);
  endproperty
  a_pll_gate: assert property (p_pll_gate) else $error("mode left with pll off");

  property p_dma_grant;
    @(posedge CLK_SYS_IN) disable iff (RST_IN)
      run_st && $past(DMA_REQ_IN) && !$past(RST_IN) |-> DMA_GRANT_OUT;
  endproperty
  a_dma_grant: assert property (p_dma_grant) else $error("dma not granted");

  property p_sleep_dma;
    @(posedge CLK_SYS_IN) disable iff (RST_IN)
      state_r == PMC_SLEEP || state_r == PMC_DEEP_SLEEP |-> !DMA_GRANT_OUT;
  endproperty
  a_sleep_dma: assert property (p_sleep_dma) else $error("dma granted in sleep");

  property p_deep_hold;
    @(posedge CLK_SYS_IN) disable iff (RST_IN)
      state_r == PMC_DEEP_SLEEP && !RTC_WAKE_IN |=> state_r == PMC_DEEP_SLEEP;
  endproperty
  a_deep_hold: assert property (p_deep_hold) else $error("deep sleep left early");

  property p_hib_hold;
    @(posedge CLK_SYS_IN) disable iff (RST_IN)
      state_r == PMC_HIBERNATE && !RTC_WAKE_IN && !CAN_WAKE_IN && !NET_RX_ON_IN && !MT_IRQ_IN |=>
      state_r == PMC_HIBERNATE;
  endproperty
  a_hib_hold: assert property (p_hib_hold) else $error("hibernate left early");

  sequence s_enter_full;
    state_r != PMC_FULL_ON ##1 state_r == PMC_FULL_ON;
  endsequence

  property p_mult_apply;
    @(posedge CLK_SYS_IN) disable iff (RST_IN)
      s_enter_full |-> PLL_MULT_OUT == mult_req_r;
  endproperty
  a_mult_apply: assert property (p_mult_apply) else $error("pending multiplier lost");

  sequence s_enter_hib;
    state_r != PMC_HIBERNATE ##1 state_r == PMC_HIBERNATE;
  endsequence

  property p_hib_stat;
    @(posedge CLK_SYS_IN) disable iff (RST_IN)
      s_enter_hib |-> irq_stat_r[PMC_EV_ENTER_HIB];
  endproperty
  a_hib_stat: assert property (p_hib_stat) else $error("hibernate event not flagged");

  property p_hib_pins;
    @(posedge CLK_SYS_IN) disable iff (RST_IN)
      state_r == PMC_HIBERNATE |-> PINS_HIZ_OUT && !CORE_SUPPLY_ON_OUT && !SYS_CLK_EN_OUT;
  endproperty
  a_hib_pins: assert property (p_hib_pins) else $error("hibernate outputs wrong");
endmodule : pmc_power_mode_controller

// >>> tb/power_mode_controller_tb.sv
// testbench: power mode controller checked against a behavioural state model
`timescale 1ns/1ps
module power_mode_controller_tb
  import pmc_pkg::*;
;
  // ********************************
  // signals and model
  // ********************************
  logic        clk;
  logic        rst;
  logic        psel;
  logic        pen;
  logic        pwr;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [4:0]  wk;
  logic        dma_req;
  logic        dma_gnt;
  logic        pll_en;
  logic        pll_byp;
  logic [5:0]  pll_mult;
  logic        core_en;
  logic        sys_en;
  logic        sup_on;
  logic        hiz;
  logic [2:0]  state;
  logic        irq;
  logic [31:0] seed;
  logic [31:0] rd;
  logic        err;
  int          num_errors = 0;
  int          samples_checked = 0;
  int          m_state;
  int          m_mult;
  int          m_pend;
  int          m_dis;
  int          e_pll[5]  = '{1, 1, 1, 0, 0};
  int          e_core[5] = '{1, 1, 0, 0, 0};
  int          e_sys[5]  = '{1, 1, 1, 0, 0};
  int          e_sup[5]  = '{1, 1, 1, 1, 0};
  int          e_hiz[5]  = '{0, 0, 0, 0, 1};
  int          e_dma[5]  = '{1, 1, 0, 0, 0};

  pmc_power_mode_controller dut_u (
    .CLK_SYS_IN(clk), .RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
    .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
    .PSLVERR_OUT(pslverr), .RTC_WAKE_IN(wk[0]), .CAN_WAKE_IN(wk[1]), .NET_RX_ON_IN(wk[2]),
    .MT_PREAMBLE_IN(wk[3]), .MT_IRQ_IN(wk[4]), .DMA_REQ_IN(dma_req),
    .DMA_GRANT_OUT(dma_gnt), .PLL_EN_OUT(pll_en), .PLL_BYPASS_OUT(pll_byp),
    .PLL_MULT_OUT(pll_mult), .CORE_CLK_EN_OUT(core_en), .SYS_CLK_EN_OUT(sys_en),
    .CORE_SUPPLY_ON_OUT(sup_on), .PINS_HIZ_OUT(hiz), .STATE_OUT(state), .IRQ_OUT(irq)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    #(100 * 20000);
    num_errors++;
    $display("watchdog expired");
    report_and_stop();
  end
  // ********************************
  // tasks
  // ********************************
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask : apb

  task automatic pulse(input int k);
    @(posedge clk);
    wk[k] <= 1'b1;
    @(posedge clk);
    wk <= 5'h00;
  endtask : pulse

  task automatic settle();
    int n;
    n = 0;
    while (state !== 3'(m_state) && n < 20) begin
      @(negedge clk);
      n++;
    end
    repeat (2) @(negedge clk);
    chk(32'(state), 32'(m_state));
    chk(32'(pll_en), 32'(e_pll[m_state] & (m_dis == 0)));
    if (m_state < 2) chk(32'(pll_byp), 32'(m_state));
    chk(32'(core_en), 32'(e_core[m_state]));
    chk(32'(sys_en), 32'(e_sys[m_state]));
    chk(32'(sup_on), 32'(e_sup[m_state]));
    chk(32'(hiz), 32'(e_hiz[m_state]));
    chk(32'(dma_gnt), 32'(e_dma[m_state]));
    chk(32'(pll_mult), 32'(m_mult));
  endtask : settle

  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop
  // ********************************
  // main sequence
  // ********************************
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    wk = 5'h00;
    dma_req = 1'b1;
    seed = 32'd11256;
    m_state = 0;
    m_mult = int'(PMC_MULT_RST);
    m_dis = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    settle();
    apb(1'b0, PMC_VREG_CTL_OFF, 32'h0);
    chk(32'(rd[1:0]), 32'(PMC_VREG_REGULATOR_FREQUENCY_FIELD_RST));
    apb(1'b0, 12'h100, 32'h0);
    chk(32'(err), 32'h1);
    chk(rd, 32'h0);
    m_mult = int'(rnd() & 32'h3F);
    apb(1'b1, PMC_PLL_CONTROL_REGISTER_OFF, 32'(m_mult) << PMC_PLL_MULT_LSB);
    settle();
    apb(1'b0, PMC_STATUS_OFF, 32'h0);
    chk(32'(rd[8:3]), 32'(m_mult));
    $display("test done: reset and full-on");
    apb(1'b1, PMC_MODE_CMD_OFF, 32'(PMC_CMD_ACTIVE));
    m_state = 1;
    settle();
    m_pend = int'(rnd() & 32'h3F);
    m_dis = 1;
    apb(1'b1, PMC_PLL_CONTROL_REGISTER_OFF, (32'(m_pend) << PMC_PLL_MULT_LSB) | 32'h2);
    apb(1'b1, PMC_MODE_CMD_OFF, 32'(PMC_CMD_FULL));
    settle();
    m_dis = 0;
    apb(1'b1, PMC_PLL_CONTROL_REGISTER_OFF, (32'(m_pend) << PMC_PLL_MULT_LSB) | 32'h1);
    apb(1'b1, PMC_MODE_CMD_OFF, 32'(PMC_CMD_SLEEP));
    m_state = 2;
    settle();
    pulse(0);
    m_state = 1;
    settle();
    apb(1'b1, PMC_PLL_CONTROL_REGISTER_OFF, 32'(m_pend) << PMC_PLL_MULT_LSB);
    for (int k = 2; k < 5; k++) begin
      apb(1'b1, PMC_MODE_CMD_OFF, 32'(PMC_CMD_SLEEP));
      m_state = 2;
      settle();
      pulse(k);
      m_state = 0;
      m_mult = m_pend;
      settle();
    end
    $display("test done: active and sleep");
    apb(1'b1, PMC_MODE_CMD_OFF, 32'(PMC_CMD_DEEP));
    m_state = 3;
    settle();
    pulse(1);
    pulse(2);
    settle();
    pulse(0);
    m_state = 1;
    settle();
    apb(1'b1, PMC_MODE_CMD_OFF, 32'(PMC_CMD_FULL));
    apb(1'b1, PMC_MODE_CMD_OFF, 32'(PMC_CMD_DEEP));
    m_state = 3;
    settle();
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    m_state = 0;
    m_mult = int'(PMC_MULT_RST);
    settle();
    $display("test done: deep sleep");
    apb(1'b1, PMC_IRQ_STAT_OFF, 32'h3F);
    apb(1'b1, PMC_IRQ_MASK_OFF, 32'h1 << PMC_EV_ENTER_HIB);
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, PMC_WAKE_CFG_OFF, (k == 3) ? 32'h2 : 32'h0);
      @(negedge clk);
      chk(32'(irq), 32'h0);
      apb(1'b0, PMC_PLL_CONTROL_REGISTER_OFF, 32'h0);
      chk(32'(rd[PMC_PLL_MULT_LSB +: 6]), 32'(m_mult));
      apb(1'b1, PMC_VREG_CTL_OFF, 32'(PMC_REGULATOR_FREQUENCY_FIELD_HIB));
      m_state = 4;
      settle();
      apb(1'b1, PMC_MODE_CMD_OFF, 32'(PMC_CMD_ACTIVE));
      if (k == 2) pulse(4);
      settle();
      pulse((k == 3) ? 4 : k);
      m_state = 0;
      settle();
      apb(1'b0, PMC_VREG_CTL_OFF, 32'h0);
      chk(32'(rd[1:0]), 32'(PMC_VREG_REGULATOR_FREQUENCY_FIELD_RST));
      chk(32'(irq), 32'h1);
      apb(1'b1, PMC_IRQ_STAT_OFF, 32'h1 << PMC_EV_ENTER_HIB);
      @(negedge clk);
      chk(32'(irq), 32'h0);
    end
    $display("test done: hibernate and interrupts");
    report_and_stop();
  end
endmodule : power_mode_controller_tb
